// file: rtl/iorb_cfg.svh
// Address map and timing constants of the I/O register bank
`ifndef IORB_CFG_SVH
`define IORB_CFG_SVH
`define IORB_A_P0 8'h00
`define IORB_A_P1 8'h01
`define IORB_A_P2 8'h02
`define IORB_A_P3 8'h03
`define IORB_A_P0_MASK 8'h04
`define IORB_A_P1_MASK 8'h05
`define IORB_A_P2_MASK 8'h06
`define IORB_A_P3_MASK 8'h07
`define IORB_A_GPIO_SETUP 8'h08
`define IORB_A_PAR_SETUP 8'h09
`define IORB_A_USB_ADDR1 8'h10
`define IORB_A_A_EP0_CNT 8'h11
`define IORB_A_A_EP0_SET 8'h12
`define IORB_A_A_EP1_CNT 8'h13
`define IORB_A_A_EP1_SET 8'h14
`define IORB_A_A_EP2_CNT 8'h15
`define IORB_A_A_EP2_SET 8'h16
`define IORB_A_USB_SC 8'h1f
`define IORB_A_GLB_MASK 8'h20
`define IORB_A_EP_MASK 8'h21
`define IORB_A_VECTOR 8'h23
`define IORB_A_TMR_LO 8'h24
`define IORB_A_TMR_HI 8'h25
`define IORB_A_WDT_KICK 8'h26
`define IORB_A_TW_CS 8'h28
`define IORB_A_TW_BYTE 8'h29
`define IORB_A_SINK_VAL 8'h30
`define IORB_A_SINK_MASK 8'h31
`define IORB_A_SINK_POL 8'h32
`define IORB_A_SINK_LVL 8'h38
`define IORB_A_SINK_LVL_TOP 8'h3f
`define IORB_A_USB_ADDR2 8'h40
`define IORB_A_B_EP0_CNT 8'h41
`define IORB_A_B_EP0_SET 8'h42
`define IORB_A_B_EP1_CNT 8'h43
`define IORB_A_B_EP1_SET 8'h44
`define IORB_A_HUB_ATT 8'h48
`define IORB_A_HUB_ACT 8'h49
`define IORB_A_HUB_RATE 8'h4a
`define IORB_A_HUB_CTRL 8'h4b
`define IORB_A_HUB_SLEEP 8'h4d
`define IORB_A_HUB_WAKE 8'h4e
`define IORB_A_HUB_SE0 8'h4f
`define IORB_A_HUB_LINE 8'h50
`define IORB_A_HUB_LOW 8'h51
`define IORB_A_CPU_SC 8'hff
`define IORB_RESET_BYTE 8'h00
`define IORB_TMR_HI_BITS 4
`define IORB_TICK_NS 1000
`define IORB_CLK_NS 4
`define IORB_TICK_CYCLES (`IORB_TICK_NS / `IORB_CLK_NS)
`endif

// file: rtl/iorb_pkg.sv
// Types shared by the I/O register bank
package iorb_pkg;
    typedef enum logic [2:0] {
        IORB_OP_NONE = 3'h1,
        IORB_OP_READ = 3'h2,
        IORB_OP_WRITE = 3'h4
    } iorb_op_t;
endpackage

// file: rtl/iorb_bank.sv
// I/O register bank: port address decode, storage and read-back
// Functional notes
// - A port read instruction returns the addressed register into the accumulator
// - A port write stores the accumulator at the immediate address
// - Indexed write targets immediate address plus index register
// - Indexed write with immediate zero selects by index register alone
// - Read-only 12-bit free timer at 1 MHz, low byte then high nibble
// - Reading the vector register returns pending vector and clears it
// - In 5-endpoint mode the second device address register is unused
// - In 5-endpoint mode second-address setups configure first-address endpoints 3, 4
// - Four write-only GPIO interrupt mask registers follow the port data
// - Eight write-only sink current level registers, one per pin
// - Hub line state, wake and single-ended-zero status are read-only
// - Hub drive-low register is readable and writable
// - Processor status and control at top address, read and write
`include "iorb_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module iorb_bank #(
    parameter int TICK_CYCLES = `IORB_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic port_read_instr,
    input wire logic port_write_instr,
    input wire logic indexed_port_write_instr,
    input wire logic [7:0] instr_addr,
    input wire logic [7:0] index_reg,
    input wire logic [7:0] acc_in,
    input wire logic five_ep_mode,
    input wire logic vector_valid,
    input wire logic [7:0] vector_in,
    input wire logic [7:0] hub_wake_in,
    input wire logic [7:0] hub_se0_in,
    input wire logic [7:0] hub_line_in,
    output logic [7:0] acc_out,
    output logic acc_valid,
    output logic vector_clear,
    output logic wdt_kick,
    output logic [7:0] gpio_value [4],
    output logic [7:0] gpio_irq_mask [4],
    output logic [7:0] sink_level [8],
    output logic [7:0] ep_setup [5],
    output logic [7:0] usb_first_addr,
    output logic [7:0] usb_second_addr,
    output logic [7:0] hub_drive_low,
    output logic [7:0] cpu_status_ctrl
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers for pin-level status
    // Hub pins move freely against ref_clk
    logic [7:0] wake_s1_reg;
    logic [7:0] wake_s2_reg;
    logic [7:0] se0_s1_reg;
    logic [7:0] se0_s2_reg;
    logic [7:0] line_s1_reg;
    logic [7:0] line_s2_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wake_s1_reg <= `IORB_RESET_BYTE;
            wake_s2_reg <= `IORB_RESET_BYTE;
            se0_s1_reg <= `IORB_RESET_BYTE;
            se0_s2_reg <= `IORB_RESET_BYTE;
            line_s1_reg <= `IORB_RESET_BYTE;
            line_s2_reg <= `IORB_RESET_BYTE;
        end else begin
            wake_s1_reg <= hub_wake_in;
            wake_s2_reg <= wake_s1_reg;
            se0_s1_reg <= hub_se0_in;
            se0_s2_reg <= se0_s1_reg;
            line_s1_reg <= hub_line_in;
            line_s2_reg <= line_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address formation and access kind
    logic [7:0] wr_addr;
    logic wr_en;
    iorb_pkg::iorb_op_t op;
    // The sum wraps at eight bits
    assign wr_addr = indexed_port_write_instr ?
        8'(instr_addr + index_reg) : instr_addr;
    assign wr_en = port_write_instr | indexed_port_write_instr;
    always_comb begin
        if (port_read_instr) begin
            op = iorb_pkg::IORB_OP_READ;
        end else if (wr_en) begin
            op = iorb_pkg::IORB_OP_WRITE;
        end else begin
            op = iorb_pkg::IORB_OP_NONE;
        end
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Plain storage: read/write and write-only registers
    logic [7:0] gpio_setup_reg;
    logic [7:0] par_setup_reg;
    logic [7:0] usb_sc_reg;
    logic [7:0] glb_mask_reg;
    logic [7:0] ep_mask_reg;
    logic [7:0] tw_cs_reg;
    logic [7:0] tw_byte_reg;
    logic [7:0] sink_val_reg;
    logic [7:0] sink_mask_reg;
    logic [7:0] sink_pol_reg;
    logic [7:0] hub_att_reg;
    logic [7:0] hub_act_reg;
    logic [7:0] hub_rate_reg;
    logic [7:0] hub_ctrl_reg;
    logic [7:0] hub_sleep_reg;
    logic [7:0] ep_cnt_reg [5];
    logic [7:0] ep_set_reg [5];
    logic [7:0] second_addr_reg;
    logic [7:0] reg_file_in;
    logic is_write;
    assign is_write = (op == iorb_pkg::IORB_OP_WRITE);
    assign reg_file_in = acc_in;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                gpio_value[i] <= `IORB_RESET_BYTE;
                gpio_irq_mask[i] <= `IORB_RESET_BYTE;
            end
            for (int i = 0; i < 8; i++) begin
                sink_level[i] <= `IORB_RESET_BYTE;
            end
            for (int i = 0; i < 5; i++) begin
                ep_cnt_reg[i] <= `IORB_RESET_BYTE;
                ep_set_reg[i] <= `IORB_RESET_BYTE;
            end
            gpio_setup_reg <= `IORB_RESET_BYTE;
            par_setup_reg <= `IORB_RESET_BYTE;
            usb_first_addr <= `IORB_RESET_BYTE;
            second_addr_reg <= `IORB_RESET_BYTE;
            usb_sc_reg <= `IORB_RESET_BYTE;
            glb_mask_reg <= `IORB_RESET_BYTE;
            ep_mask_reg <= `IORB_RESET_BYTE;
            tw_cs_reg <= `IORB_RESET_BYTE;
            tw_byte_reg <= `IORB_RESET_BYTE;
            sink_val_reg <= `IORB_RESET_BYTE;
            sink_mask_reg <= `IORB_RESET_BYTE;
            sink_pol_reg <= `IORB_RESET_BYTE;
            hub_att_reg <= `IORB_RESET_BYTE;
            hub_act_reg <= `IORB_RESET_BYTE;
            hub_rate_reg <= `IORB_RESET_BYTE;
            hub_ctrl_reg <= `IORB_RESET_BYTE;
            hub_sleep_reg <= `IORB_RESET_BYTE;
            hub_drive_low <= `IORB_RESET_BYTE;
            cpu_status_ctrl <= `IORB_RESET_BYTE;
        end else if (is_write) begin
            case (wr_addr)
                `IORB_A_P0: gpio_value[0] <= reg_file_in;
                `IORB_A_P1: gpio_value[1] <= reg_file_in;
                `IORB_A_P2: gpio_value[2] <= reg_file_in;
                `IORB_A_P3: gpio_value[3] <= reg_file_in;
                `IORB_A_P0_MASK: gpio_irq_mask[0] <= reg_file_in;
                `IORB_A_P1_MASK: gpio_irq_mask[1] <= reg_file_in;
                `IORB_A_P2_MASK: gpio_irq_mask[2] <= reg_file_in;
                `IORB_A_P3_MASK: gpio_irq_mask[3] <= reg_file_in;
                `IORB_A_GPIO_SETUP: gpio_setup_reg <= reg_file_in;
                `IORB_A_PAR_SETUP: par_setup_reg <= reg_file_in;
                `IORB_A_USB_ADDR1: usb_first_addr <= reg_file_in;
                `IORB_A_A_EP0_CNT: ep_cnt_reg[0] <= reg_file_in;
                `IORB_A_A_EP0_SET: ep_set_reg[0] <= reg_file_in;
                `IORB_A_A_EP1_CNT: ep_cnt_reg[1] <= reg_file_in;
                `IORB_A_A_EP1_SET: ep_set_reg[1] <= reg_file_in;
                `IORB_A_A_EP2_CNT: ep_cnt_reg[2] <= reg_file_in;
                `IORB_A_A_EP2_SET: ep_set_reg[2] <= reg_file_in;
                `IORB_A_USB_SC: usb_sc_reg <= reg_file_in;
                `IORB_A_GLB_MASK: glb_mask_reg <= reg_file_in;
                `IORB_A_EP_MASK: ep_mask_reg <= reg_file_in;
                `IORB_A_TW_CS: tw_cs_reg <= reg_file_in;
                `IORB_A_TW_BYTE: tw_byte_reg <= reg_file_in;
                `IORB_A_SINK_VAL: sink_val_reg <= reg_file_in;
                `IORB_A_SINK_MASK: sink_mask_reg <= reg_file_in;
                `IORB_A_SINK_POL: sink_pol_reg <= reg_file_in;
                `IORB_A_USB_ADDR2: second_addr_reg <= reg_file_in;
                `IORB_A_B_EP0_CNT: ep_cnt_reg[3] <= reg_file_in;
                `IORB_A_B_EP0_SET: ep_set_reg[3] <= reg_file_in;
                `IORB_A_B_EP1_CNT: ep_cnt_reg[4] <= reg_file_in;
                `IORB_A_B_EP1_SET: ep_set_reg[4] <= reg_file_in;
                `IORB_A_HUB_ATT: hub_att_reg <= reg_file_in;
                `IORB_A_HUB_ACT: hub_act_reg <= reg_file_in;
                `IORB_A_HUB_RATE: hub_rate_reg <= reg_file_in;
                `IORB_A_HUB_CTRL: hub_ctrl_reg <= reg_file_in;
                `IORB_A_HUB_SLEEP: hub_sleep_reg <= reg_file_in;
                `IORB_A_HUB_LOW: hub_drive_low <= reg_file_in;
                `IORB_A_CPU_SC: cpu_status_ctrl <= reg_file_in;
                // Sink levels form a range, so they sit outside the items
                default: begin
                    if (wr_addr >= `IORB_A_SINK_LVL && wr_addr <= `IORB_A_SINK_LVL_TOP) begin
                        sink_level[3'(wr_addr - `IORB_A_SINK_LVL)] <= reg_file_in;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Endpoint setup outputs; second address idle in 5-endpoint mode
    // Slots 3 and 4 serve the first address in that mode
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 5; i++) begin
                ep_setup[i] <= `IORB_RESET_BYTE;
            end
            usb_second_addr <= `IORB_RESET_BYTE;
        end else begin
            for (int i = 0; i < 5; i++) begin
                ep_setup[i] <= ep_set_reg[i];
            end
            usb_second_addr <= five_ep_mode ? `IORB_RESET_BYTE : second_addr_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Free-running 12-bit microsecond timer
    // Bytes are not latched: a carry may fall between reads
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_reg;
    logic [11:0] timer_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tick_cnt_reg <= '0;
            timer_reg <= 12'h000;
        end else if (tick_cnt_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
            timer_reg <= timer_reg + 12'h001;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-back mux
    logic [7:0] rd_data;
    always_comb begin
        case (instr_addr)
            `IORB_A_P0: rd_data = gpio_value[0];
            `IORB_A_P1: rd_data = gpio_value[1];
            `IORB_A_P2: rd_data = gpio_value[2];
            `IORB_A_P3: rd_data = gpio_value[3];
            `IORB_A_GPIO_SETUP: rd_data = gpio_setup_reg;
            `IORB_A_PAR_SETUP: rd_data = par_setup_reg;
            `IORB_A_USB_ADDR1: rd_data = usb_first_addr;
            `IORB_A_A_EP0_CNT: rd_data = ep_cnt_reg[0];
            `IORB_A_A_EP0_SET: rd_data = ep_set_reg[0];
            `IORB_A_A_EP1_CNT: rd_data = ep_cnt_reg[1];
            `IORB_A_A_EP1_SET: rd_data = ep_set_reg[1];
            `IORB_A_A_EP2_CNT: rd_data = ep_cnt_reg[2];
            `IORB_A_A_EP2_SET: rd_data = ep_set_reg[2];
            `IORB_A_USB_SC: rd_data = usb_sc_reg;
            `IORB_A_GLB_MASK: rd_data = glb_mask_reg;
            `IORB_A_EP_MASK: rd_data = ep_mask_reg;
            `IORB_A_VECTOR: rd_data = vector_valid ? vector_in : `IORB_RESET_BYTE;
            `IORB_A_TMR_LO: rd_data = timer_reg[7:0];
            `IORB_A_TMR_HI: rd_data = {4'h0, timer_reg[11:8]};
            `IORB_A_TW_CS: rd_data = tw_cs_reg;
            `IORB_A_TW_BYTE: rd_data = tw_byte_reg;
            `IORB_A_SINK_VAL: rd_data = sink_val_reg;
            `IORB_A_USB_ADDR2: rd_data = second_addr_reg;
            `IORB_A_B_EP0_CNT: rd_data = ep_cnt_reg[3];
            `IORB_A_B_EP0_SET: rd_data = ep_set_reg[3];
            `IORB_A_B_EP1_CNT: rd_data = ep_cnt_reg[4];
            `IORB_A_B_EP1_SET: rd_data = ep_set_reg[4];
            `IORB_A_HUB_ATT: rd_data = hub_att_reg;
            `IORB_A_HUB_ACT: rd_data = hub_act_reg;
            `IORB_A_HUB_RATE: rd_data = hub_rate_reg;
            `IORB_A_HUB_CTRL: rd_data = hub_ctrl_reg;
            `IORB_A_HUB_SLEEP: rd_data = hub_sleep_reg;
            `IORB_A_HUB_WAKE: rd_data = wake_s2_reg;
            `IORB_A_HUB_SE0: rd_data = se0_s2_reg;
            `IORB_A_HUB_LINE: rd_data = line_s2_reg;
            `IORB_A_HUB_LOW: rd_data = hub_drive_low;
            `IORB_A_CPU_SC: rd_data = cpu_status_ctrl;
            // Write-only and unassigned addresses read as zero
            default: rd_data = `IORB_RESET_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read answer, vector clear and watchdog kick pulses
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            acc_out <= `IORB_RESET_BYTE;
            acc_valid <= 1'b0;
        end else begin
            acc_valid <= (op == iorb_pkg::IORB_OP_READ);
            acc_out <= (op == iorb_pkg::IORB_OP_READ) ? rd_data : acc_out;
        end
    end

    // Clear only a real vector, so an idle read loses nothing
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            vector_clear <= 1'b0;
        end else begin
            vector_clear <= (op == iorb_pkg::IORB_OP_READ) &&
                hit(instr_addr, `IORB_A_VECTOR) && vector_valid;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wdt_kick <= 1'b0;
        end else begin
            wdt_kick <= is_write && hit(wr_addr, `IORB_A_WDT_KICK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_read_answer: assert property (@(posedge ref_clk) disable iff (reset)
        port_read_instr |=> acc_valid && acc_out == $past(rd_data))
        else $error("read answer wrong");

    a_direct_write: assert property (@(posedge ref_clk) disable iff (reset)
        port_write_instr && !indexed_port_write_instr && !port_read_instr &&
        instr_addr == `IORB_A_HUB_LOW |=> hub_drive_low == $past(acc_in))
        else $error("direct write lost");

    a_indexed_sum: assert property (@(posedge ref_clk) disable iff (reset)
        indexed_port_write_instr && !port_read_instr &&
        8'(instr_addr + index_reg) == `IORB_A_CPU_SC
        |=> cpu_status_ctrl == $past(acc_in))
        else $error("indexed write address wrong");

    a_indexed_zero: assert property (@(posedge ref_clk) disable iff (reset)
        indexed_port_write_instr && !port_read_instr && instr_addr == 8'h00 &&
        index_reg == `IORB_A_HUB_LOW |=> hub_drive_low == $past(acc_in))
        else $error("index-only select wrong");

    a_timer_step: assert property (@(posedge ref_clk) disable iff (reset)
        tick_cnt_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)
        |=> timer_reg == 12'($past(timer_reg) + 12'h001))
        else $error("timer did not step");

    a_vector_clear: assert property (@(posedge ref_clk) disable iff (reset)
        port_read_instr && instr_addr == `IORB_A_VECTOR && vector_valid
        |=> vector_clear && acc_out == $past(vector_in)
        ##1 (!vector_clear || $past(port_read_instr)))
        else $error("vector clear wrong");

    a_second_idle: assert property (@(posedge ref_clk) disable iff (reset)
        five_ep_mode |=> usb_second_addr == 8'h00)
        else $error("second address active");

    a_wo_readzero: assert property (@(posedge ref_clk) disable iff (reset)
        port_read_instr && instr_addr == `IORB_A_WDT_KICK |=> acc_out == 8'h00)
        else $error("write-only read not zero");

    a_mask_write: assert property (@(posedge ref_clk) disable iff (reset)
        is_write && wr_addr == `IORB_A_P3_MASK |=> gpio_irq_mask[3] == $past(acc_in))
        else $error("mask write lost");

    a_mask_readzero: assert property (@(posedge ref_clk) disable iff (reset)
        port_read_instr && instr_addr == `IORB_A_P0_MASK |=> acc_out == `IORB_RESET_BYTE)
        else $error("mask read not zero");

    a_sink_write: assert property (@(posedge ref_clk) disable iff (reset)
        is_write && wr_addr == `IORB_A_SINK_LVL_TOP |=> sink_level[7] == $past(acc_in))
        else $error("sink write lost");

    a_line_read: assert property (@(posedge ref_clk) disable iff (reset)
        port_read_instr && instr_addr == `IORB_A_HUB_LINE |=> acc_out == $past(line_s2_reg))
        else $error("line state read wrong");
endmodule // iorb_bank
`default_nettype wire

// file: verif/iorb_core_model.sv
// Core model issuing port read, port write and indexed port write instructions
`timescale 1ns/100ps
`default_nettype none
module iorb_core_model (
    input wire logic ref_clk,
    output logic port_read_instr,
    output logic port_write_instr,
    output logic indexed_port_write_instr,
    output logic [7:0] instr_addr,
    output logic [7:0] index_reg,
    output logic [7:0] acc_in,
    input wire logic [7:0] acc_out,
    input wire logic acc_valid
);
    initial begin
        port_read_instr = 1'b0;
        port_write_instr = 1'b0;
        indexed_port_write_instr = 1'b0;
        instr_addr = 8'h00;
        index_reg = 8'h00;
        acc_in = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic is_mapped(input logic [7:0] a);
        return a inside {[8'h00:8'h09], [8'h10:8'h16], 8'h1f, [8'h20:8'h21], [8'h23:8'h26],
            [8'h28:8'h29], [8'h30:8'h32], [8'h38:8'h44], [8'h48:8'h4b], [8'h4d:8'h51], 8'hff};
    endfunction
    // Idle lines show the inverse of the last value, never a stale copy
    task automatic release_bus();
        port_read_instr = 1'b0;
        port_write_instr = 1'b0;
        indexed_port_write_instr = 1'b0;
        instr_addr = ~instr_addr;
        index_reg = ~index_reg;
        acc_in = ~acc_in;
    endtask
    task automatic io_read(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge ref_clk);
        port_read_instr = 1'b1;
        instr_addr = a;
        @(negedge ref_clk);
        d = acc_out;
        v = acc_valid;
        release_bus();
    endtask
    task automatic io_write(input logic ix, input logic [7:0] a, input logic [7:0] x,
        input logic [7:0] d);
        @(negedge ref_clk);
        // Unassigned addresses are never written
        if (is_mapped(ix ? 8'(a + x) : a)) begin
            port_write_instr = !ix;
            indexed_port_write_instr = ix;
            instr_addr = a;
            index_reg = x;
            acc_in = d;
        end
        @(negedge ref_clk);
        release_bus();
    endtask
endmodule // iorb_core_model
`default_nettype wire

// file: verif/test_io_register_decode_bank.sv
// Self-checking bench for the I/O register bank
`timescale 1ns/100ps
`default_nettype none
module test_io_register_decode_bank;
    typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data;
        logic [7:0] exp;} iorb_row_t;
    localparam iorb_row_t ROWS [29] = '{
        '{1'b1, 8'h00, 8'h5a, 8'h5a}, '{1'b1, 8'h03, 8'hc3, 8'hc3}, '{1'b1, 8'h04, 8'ha5, 8'h00},
        '{1'b1, 8'h07, 8'h3c, 8'h00}, '{1'b1, 8'h08, 8'h11, 8'h11}, '{1'b1, 8'h09, 8'h22, 8'h22},
        '{1'b1, 8'h10, 8'h7f, 8'h7f}, '{1'b1, 8'h12, 8'h4c, 8'h4c}, '{1'b1, 8'h16, 8'h44, 8'h44},
        '{1'b1, 8'h1f, 8'h81, 8'h81}, '{1'b1, 8'h21, 8'h0f, 8'h0f}, '{1'b1, 8'h28, 8'h99, 8'h99},
        '{1'b1, 8'h29, 8'h66, 8'h66}, '{1'b1, 8'h30, 8'h12, 8'h12}, '{1'b1, 8'h31, 8'hff, 8'h00},
        '{1'b1, 8'h32, 8'hff, 8'h00}, '{1'b1, 8'h38, 8'h01, 8'h00}, '{1'b1, 8'h3f, 8'h0f, 8'h00},
        '{1'b1, 8'h41, 8'he7, 8'he7}, '{1'b1, 8'h48, 8'h0e, 8'h0e}, '{1'b1, 8'h4d, 8'h1e, 8'h1e},
        '{1'b1, 8'h4e, 8'h00, 8'h96}, '{1'b1, 8'h4f, 8'h00, 8'h69}, '{1'b0, 8'h50, 8'h00, 8'h3c},
        '{1'b1, 8'h51, 8'haa, 8'haa}, '{1'b1, 8'hff, 8'h55, 8'h55}, '{1'b0, 8'h0a, 8'h00, 8'h00},
        '{1'b0, 8'h22, 8'h00, 8'h00}, '{1'b1, 8'h26, 8'h5a, 8'h00}};
    logic ref_clk;
    logic reset;
    logic port_read_instr;
    logic port_write_instr;
    logic indexed_port_write_instr;
    logic [7:0] instr_addr;
    logic [7:0] index_reg;
    logic [7:0] acc_in;
    logic five_ep_mode;
    logic vector_valid;
    logic [7:0] vector_in;
    logic [7:0] hub_wake_in;
    logic [7:0] hub_se0_in;
    logic [7:0] hub_line_in;
    logic [7:0] acc_out;
    logic acc_valid;
    logic vector_clear;
    logic wdt_kick;
    logic [7:0] gpio_value [4];
    logic [7:0] gpio_irq_mask [4];
    logic [7:0] sink_level [8];
    logic [7:0] ep_setup [5];
    logic [7:0] usb_first_addr;
    logic [7:0] usb_second_addr;
    logic [7:0] hub_drive_low;
    logic [7:0] cpu_status_ctrl;
    logic [7:0] rd;
    logic [7:0] t0;
    logic vld;
    int fail_count = 0;
    int compares = 0;
    ////////////////////////////////////////////////////////////////////////////////
    iorb_bank #(.TICK_CYCLES(4)) iorb_bank_inst (.ref_clk(ref_clk), .reset(reset),
        .port_read_instr(port_read_instr), .port_write_instr(port_write_instr),
        .indexed_port_write_instr(indexed_port_write_instr), .instr_addr(instr_addr),
        .index_reg(index_reg), .acc_in(acc_in), .five_ep_mode(five_ep_mode),
        .vector_valid(vector_valid), .vector_in(vector_in), .hub_wake_in(hub_wake_in),
        .hub_se0_in(hub_se0_in), .hub_line_in(hub_line_in), .acc_out(acc_out),
        .acc_valid(acc_valid), .vector_clear(vector_clear), .wdt_kick(wdt_kick),
        .gpio_value(gpio_value), .gpio_irq_mask(gpio_irq_mask), .sink_level(sink_level),
        .ep_setup(ep_setup), .usb_first_addr(usb_first_addr), .usb_second_addr(usb_second_addr),
        .hub_drive_low(hub_drive_low), .cpu_status_ctrl(cpu_status_ctrl));
    iorb_core_model iorb_core_model_inst (.ref_clk(ref_clk), .port_read_instr(port_read_instr),
        .port_write_instr(port_write_instr), .indexed_port_write_instr(indexed_port_write_instr),
        .instr_addr(instr_addr), .index_reg(index_reg), .acc_in(acc_in), .acc_out(acc_out),
        .acc_valid(acc_valid));
    ////////////////////////////////////////////////////////////////////////////////
    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        five_ep_mode = 1'b0;
        vector_valid = 1'b0;
        vector_in = 8'h00;
        hub_wake_in = 8'h96;
        hub_se0_in = 8'h69;
        hub_line_in = 8'h3c;
        repeat (16) @(negedge ref_clk);
        reset = 1'b0;
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) iorb_core_model_inst.io_write(1'b0, ROWS[i].addr, 8'h00, ROWS[i].data);
            iorb_core_model_inst.io_read(ROWS[i].addr, rd, vld);
            check_bit(vld, 1'b1, "read answer");
            check_byte(rd, ROWS[i].exp, "read back");
        end
        check_byte(gpio_value[3], 8'hc3, "port value");
        check_byte(gpio_irq_mask[0], 8'ha5, "port mask");
        check_byte(gpio_irq_mask[3], 8'h3c, "port mask");
        check_byte(sink_level[0], 8'h01, "sink level");
        check_byte(sink_level[7], 8'h0f, "sink level");
        check_byte(ep_setup[0], 8'h4c, "endpoint setup");
        check_byte(usb_first_addr, 8'h7f, "first address");
        $display("test table done");
        iorb_core_model_inst.io_read(8'h24, t0, vld);
        repeat (38) @(negedge ref_clk);
        iorb_core_model_inst.io_read(8'h24, rd, vld);
        check_byte(8'(rd - t0), 8'h0a, "timer step");
        iorb_core_model_inst.io_read(8'h25, rd, vld);
        check_byte(rd & 8'hf0, 8'h00, "timer high nibble");
        $display("test timer done");
        vector_in = 8'h1a;
        vector_valid = 1'b1;
        iorb_core_model_inst.io_read(8'h23, rd, vld);
        check_byte(rd, 8'h1a, "vector");
        check_bit(vector_clear, 1'b1, "vector clear");
        vector_valid = 1'b0;
        @(negedge ref_clk);
        check_bit(vector_clear, 1'b0, "clear pulse");
        iorb_core_model_inst.io_write(1'b0, 8'h23, 8'h00, 8'h77);
        iorb_core_model_inst.io_read(8'h23, rd, vld);
        check_byte(rd, 8'h00, "vector not writable");
        iorb_core_model_inst.io_write(1'b0, 8'h26, 8'h00, 8'h5a);
        check_bit(wdt_kick, 1'b1, "watchdog kick");
        @(negedge ref_clk);
        check_bit(wdt_kick, 1'b0, "kick pulse");
        $display("test vector done");
        iorb_core_model_inst.io_write(1'b1, 8'h00, 8'h51, 8'h3e);
        check_byte(hub_drive_low, 8'h3e, "indexed zero");
        iorb_core_model_inst.io_write(1'b1, 8'h38, 8'h07, 8'hc1);
        check_byte(sink_level[7], 8'hc1, "indexed sum");
        iorb_core_model_inst.io_write(1'b1, 8'hf0, 8'h0f, 8'h9d);
        check_byte(cpu_status_ctrl, 8'h9d, "indexed top");
        $display("test indexed done");
        iorb_core_model_inst.io_write(1'b0, 8'h40, 8'h00, 8'h2b);
        @(negedge ref_clk);
        check_byte(usb_second_addr, 8'h2b, "second address");
        five_ep_mode = 1'b1;
        iorb_core_model_inst.io_write(1'b0, 8'h42, 8'h00, 8'h63);
        iorb_core_model_inst.io_write(1'b0, 8'h44, 8'h00, 8'h64);
        @(negedge ref_clk);
        check_byte(usb_second_addr, 8'h00, "unused address");
        check_byte(ep_setup[3], 8'h63, "endpoint three");
        check_byte(ep_setup[4], 8'h64, "endpoint four");
        $display("test five endpoint done");
        reset = 1'b1;
        @(negedge ref_clk);
        check_byte(cpu_status_ctrl, 8'h00, "reset status");
        check_byte(hub_drive_low, 8'h00, "reset drive low");
        check_byte(gpio_value[0], 8'h00, "reset port");
        check_byte(acc_out, 8'h00, "reset read data");
        reset = 1'b0;
        $display("test reset done");
        test_done();
    end
endmodule // test_io_register_decode_bank
`default_nettype wire
